// ==== arp_readback_port.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "arp_params.svh"

module arp_readback_port
    import arp_pkg::*;
#(
    parameter int RES_W      = `ARP_RES_W,     // 12 or 10 result bits
    parameter int SEQ_DEPTH  = `ARP_SEQ_DEPTH, // Sequencer locations
    parameter int FIFO_DEPTH = `ARP_FIFO_DEPTH // Result buffer words
) (
    // Clock and reset
    input  wire logic                            clk,
    input  wire logic                            reset_n,
    // Host strobes and mode pins, asynchronous
    input  wire logic                            chipSelect_n,
    input  wire logic                            readStrobe_n,
    input  wire logic                            sampleLaunch_n,
    input  wire logic                            modePinZero,
    input  wire logic                            modePinOne,
    // Configuration pins, asynchronous
    input  wire logic                            pairInputSelect,
    input  wire logic [2:0]                      channelAddrIn,
    input  wire logic                            polaritySpanSelect,
    input  wire logic                            gainSelect,
    // Sequencer load port, same clock
    input  wire logic                            seqLoadValid,
    input  wire logic [$clog2(SEQ_DEPTH)-1:0]    seqLoadAddr,
    input  wire logic [`ARP_CF_W-1:0]            seqLoadData,
    // Converter core, same clock
    output logic                                 convStart,
    output logic                                 convReady,
    input  wire logic                            convDone,
    input  wire logic [RES_W-1:0]                convCode,
    // Multiplexer and range control
    output logic [2:0]                           muxPosSel,
    output logic [2:0]                           muxNegSel,
    output logic                                 muxNegCommon,
    output logic                                 spanBipolar,
    output logic                                 gainUnity,
    // Parallel output pins
    output logic [RES_W-1:0]                     resultPins,
    output logic                                 pairmodeOutBit,
    output logic                                 channelAddrOutHi,
    output logic                                 channelAddrOutMid,
    output logic                                 channelAddrOutLo,
    output logic                                 pinsOe,
    output logic                                 busy
);
    localparam int SAW = $clog2(SEQ_DEPTH);
    localparam int CW  = `ARP_RES_W;
    localparam int SH  = `ARP_SHARED_W;

    // Whole port state
    typedef struct packed {
        logic [`ARP_SI_W-1:0]                   s1;       // Sync stage one
        logic [`ARP_SI_W-1:0]                   s2;       // Sync stage two
        logic [`ARP_SI_W-1:0]                   s3;       // Sync stage three
        logic [`ARP_SI_W-1:0]                   f;        // Agreed pin levels
        arp_state_t                             st;       // Port state
        arp_word_t                              conv;     // Settings of running conversion
        logic                                   coreHeld; // Core word waiting
        arp_word_t                              coreWord; // Word from the core
        arp_word_t                              outWord;  // Output latch
        logic [SEQ_DEPTH-1:0][`ARP_CF_W-1:0]    seq;      // Sequencer memory
        logic [SAW-1:0]                         seqPtr;   // Current location
        logic                                   convStart;
        logic                                   convReady;
        logic [2:0]                             muxPos;
        logic [2:0]                             muxNeg;
        logic                                   negCommon;
        logic                                   spanBip;
        logic                                   gainOne;
        logic [RES_W-1:0]                       resultPins;
        logic                                   pairBit;
        logic [2:0]                             addrOut;
        logic                                   pinsOe;
        logic                                   busy;
    } arp_port_st_t;

    arp_port_st_t           q;          // Registered state
    arp_port_st_t           d;          // Next state
    logic [`ARP_SI_W-1:0]   pinVec;     // Raw pins
    logic [`ARP_SI_W-1:0]   agree;      // Stages two and three equal
    logic                   launchFall; // Agreed launch edge
    logic                   rdRise;     // Agreed read release
    logic                   selected;   // Chip select low
    logic                   reading;    // Read in progress
    logic                   rbMode;     // Mode pins say readback
    logic                   outPop;     // Output latch loads
    logic [RES_W-1:0]       code;       // Core code after coding
    logic [`ARP_CF_W-1:0]   entry;      // Sequencer entry on show

    // Buffer between core and output latch
    arp_stream_if #(.W($bits(arp_word_t))) toFifo ();
    arp_stream_if #(.W($bits(arp_word_t))) fromFifo ();

    arp_word_fifo #(
        .WIDTH ($bits(arp_word_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk     (clk),
        .reset_n (reset_n),
        .inQ     (toFifo),
        .outQ    (fromFifo)
    );

    assign pinVec = {chipSelect_n, readStrobe_n, sampleLaunch_n, modePinOne,
                     modePinZero, pairInputSelect, channelAddrIn,
                     polaritySpanSelect, gainSelect};

    // The held core word is offered to the buffer
    assign toFifo.valid = q.coreHeld;
    assign toFifo.data  = q.coreWord;

    // Next-state logic
    always_comb begin
        d = q;
        // Three-stage synchroniser; first stage feeds only the second
        d.s1  = pinVec;
        d.s2  = q.s1;
        d.s3  = q.s2;
        agree = ~(q.s2 ^ q.s3);
        d.f   = (agree & q.s3) | (~agree & q.f);
        // Edges and levels on agreed pins
        launchFall = q.f[`ARP_SI_LAUNCH] & ~d.f[`ARP_SI_LAUNCH];
        rdRise     = ~q.f[`ARP_SI_RD] & d.f[`ARP_SI_RD];
        selected   = ~d.f[`ARP_SI_CS];
        reading    = selected & ~d.f[`ARP_SI_RD];
        rbMode     = d.f[`ARP_SI_M1] & ~d.f[`ARP_SI_M0];
        d.convStart = 1'b0;

        // Sequencer memory load
        if (seqLoadValid) begin
            d.seq[seqLoadAddr] = seqLoadData;
        end

        // Held word leaves once the buffer takes it
        if (q.coreHeld && toFifo.ready) begin
            d.coreHeld = 1'b0;
        end
        // Core gives offset binary; flipping the MSB yields two's complement
        code = convCode;
        if (q.conv.bipolar) begin
            code[RES_W-1] = ~convCode[RES_W-1];
        end
        if (convDone && !q.coreHeld) begin
            d.coreHeld      = 1'b1;
            d.coreWord      = q.conv;
            d.coreWord.code = CW'(code);
        end
        // Core may only finish while a holding slot is free
        d.convReady = ~d.coreHeld;

        // Latch never changes under a read, so a word is never torn
        fromFifo.ready = ~reading & ~rbMode;
        outPop         = fromFifo.valid & fromFifo.ready;
        if (outPop) begin
            d.outWord = fromFifo.data;
        end

        // Port state machine
        case (q.st)
            ARP_IDLE: begin
                if (rbMode) begin
                    d.st     = ARP_READBACK;
                    d.seqPtr = '0;
                end else if (launchFall && selected) begin
                    d.st             = ARP_CONV;
                    d.convStart      = 1'b1;
                    d.conv.pairMode  = d.f[`ARP_SI_PAIR_INPUT_SELECT];
                    d.conv.chanAddr  = d.f[`ARP_SI_ADDR +: 3];
                    d.conv.bipolar   = d.f[`ARP_SI_UNI];
                    d.conv.code      = '0;
                    // Pairs are even/odd neighbours of the chosen channel
                    d.muxPos    = d.f[`ARP_SI_ADDR +: 3];
                    d.muxNeg    = {d.f[`ARP_SI_ADDR+1 +: 2], ~d.f[`ARP_SI_ADDR]};
                    d.negCommon = ~d.f[`ARP_SI_PAIR_INPUT_SELECT];
                    d.spanBip   = d.f[`ARP_SI_UNI];
                    d.gainOne   = d.f[`ARP_SI_PGA];
                end
            end
            ARP_CONV: begin
                // Busy ends only when the result sits in the latch
                if (outPop) begin
                    d.st = ARP_IDLE;
                end
            end
            ARP_READBACK: begin
                if (!rbMode) begin
                    d.st = ARP_IDLE;
                end else if (rdRise && selected) begin
                    d.seqPtr = (q.seqPtr == SAW'(SEQ_DEPTH-1)) ? '0 : q.seqPtr + 1'b1;
                end
            end
            default: begin
                d.st = ARP_IDLE;
            end
        endcase

        // Busy high only when idle
        d.busy   = (d.st == ARP_IDLE);
        // Drivers follow the read strobe while chip select is low
        d.pinsOe = reading;

        // Pin values
        entry = d.seq[d.seqPtr];
        if (rbMode) begin
            d.pairBit    = entry[`ARP_CF_PAIR_INPUT_SELECT];
            d.addrOut    = entry[`ARP_CF_ADDR +: 3];
            d.resultPins = {entry[`ARP_CF_POL], entry[`ARP_CF_GAIN],
                            entry[`ARP_CF_EOS], {(RES_W-SH){1'b0}}};
        end else begin
            d.pairBit    = d.outWord.pairMode;
            d.addrOut    = d.outWord.chanAddr;
            // Top three result bits land on the shared pins for either width
            d.resultPins = d.outWord.code[RES_W-1:0];
        end
    end

    // State register, synchronous reset to idle levels
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            q           <= '0;
            q.s1        <= `ARP_SI_RST;
            q.s2        <= `ARP_SI_RST;
            q.s3        <= `ARP_SI_RST;
            q.f         <= `ARP_SI_RST;
            q.convReady <= 1'b1;
            q.busy      <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    assign convStart         = q.convStart;
    assign convReady         = q.convReady;
    assign muxPosSel         = q.muxPos;
    assign muxNegSel         = q.muxNeg;
    assign muxNegCommon      = q.negCommon;
    assign spanBipolar       = q.spanBip;
    assign gainUnity         = q.gainOne;
    assign resultPins        = q.resultPins;
    assign pairmodeOutBit    = q.pairBit;
    assign channelAddrOutHi  = q.addrOut[2];
    assign channelAddrOutMid = q.addrOut[1];
    assign channelAddrOutLo  = q.addrOut[0];
    assign pinsOe            = q.pinsOe;
    assign busy              = q.busy;

    // Checks on the port behaviour
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_oe_read_only: assert property (
        pinsOe |-> (!q.f[`ARP_SI_RD] && !q.f[`ARP_SI_CS]))
        else $error("pins driven without a read");

    a_conv_pair_bit: assert property (
        (pinsOe && !(q.f[`ARP_SI_M1] && !q.f[`ARP_SI_M0]))
        |-> (pairmodeOutBit == q.outWord.pairMode))
        else $error("pair-mode bit differs from result word");

    a_conv_addr_out: assert property (
        (pinsOe && !(q.f[`ARP_SI_M1] && !q.f[`ARP_SI_M0]))
        |-> ({channelAddrOutHi, channelAddrOutMid, channelAddrOutLo}
             == q.outWord.chanAddr))
        else $error("address pins differ from result word");

    a_rb_pair_bit: assert property (
        (pinsOe && q.st == ARP_READBACK && q.f[`ARP_SI_M1] && !q.f[`ARP_SI_M0])
        |-> (pairmodeOutBit == q.seq[q.seqPtr][`ARP_CF_PAIR_INPUT_SELECT]))
        else $error("readback pair bit wrong");

    a_rb_addr_out: assert property (
        (pinsOe && q.st == ARP_READBACK && q.f[`ARP_SI_M1] && !q.f[`ARP_SI_M0])
        |-> ({channelAddrOutHi, channelAddrOutMid, channelAddrOutLo}
             == q.seq[q.seqPtr][`ARP_CF_ADDR +: 3]))
        else $error("readback address wrong");

    a_rb_flag_bits: assert property (
        (pinsOe && q.st == ARP_READBACK && q.f[`ARP_SI_M1] && !q.f[`ARP_SI_M0])
        |-> (resultPins[RES_W-1 -: SH] == {q.seq[q.seqPtr][`ARP_CF_POL],
             q.seq[q.seqPtr][`ARP_CF_GAIN], q.seq[q.seqPtr][`ARP_CF_EOS]}))
        else $error("readback flag bits wrong");

    a_rb_low_zero: assert property (
        (pinsOe && q.st == ARP_READBACK && q.f[`ARP_SI_M1] && !q.f[`ARP_SI_M0])
        |-> (resultPins[RES_W-SH-1:0] == '0))
        else $error("readback low bits not zero");

    a_launch_start: assert property (
        (q.st == ARP_IDLE && launchFall && selected && !rbMode)
        |=> (convStart && !busy) ##1 (!convStart && !busy))
        else $error("launch edge did not start a conversion");

    a_rb_busy_low: assert property (
        (q.st == ARP_IDLE && rbMode) |=> (!busy throughout (q.st == ARP_READBACK)[*2]))
        else $error("busy not held low in readback");

    a_rb_advance: assert property (
        (q.st == ARP_READBACK && rbMode && rdRise && selected)
        |=> (q.seqPtr == SAW'($past(q.seqPtr) + 1'b1)))
        else $error("read release did not advance location");

    a_busy_rise: assert property (
        $rose(busy) |-> ($past(outPop) || $past(q.st == ARP_READBACK)))
        else $error("busy rose without a latched result");

    a_bip_msb: assert property (
        (convDone && !q.coreHeld && q.conv.bipolar)
        |=> (q.coreWord.code[RES_W-1] == !$past(convCode[RES_W-1])))
        else $error("bipolar code not two's complement");

    a_mux_pairing: assert property (
        convStart |-> (muxNegCommon == !q.conv.pairMode)
        && (muxNegSel == {muxPosSel[2:1], ~muxPosSel[0]}))
        else $error("multiplexer pairing wrong");

endmodule : arp_readback_port

`default_nettype wire

// ==== arp_params.svh ====
`ifndef ARP_PARAMS_SVH
`define ARP_PARAMS_SVH

// Bit positions in the synchronised pin vector
`define ARP_SI_PGA    0
`define ARP_SI_UNI    1
`define ARP_SI_ADDR   2
`define ARP_SI_PAIR_INPUT_SELECT   5
`define ARP_SI_M0     6
`define ARP_SI_M1     7
`define ARP_SI_LAUNCH 8
`define ARP_SI_RD     9
`define ARP_SI_CS     10
`define ARP_SI_W      11

// Pin vector value after reset: chip select, strobes and mode pin zero idle high,
// so a host holding mode pin one high at reset cannot fake a readback entry
`define ARP_SI_RST    11'h740

// Field positions in one sequencer entry
`define ARP_CF_EOS    0
`define ARP_CF_GAIN   1
`define ARP_CF_POL    2
`define ARP_CF_ADDR   3
`define ARP_CF_PAIR_INPUT_SELECT   6
`define ARP_CF_W      7

// Sizes
`define ARP_SEQ_DEPTH  16
`define ARP_RES_W      12
`define ARP_SHARED_W   3
`define ARP_FIFO_DEPTH 2

`endif

// ==== arp_pkg.sv ====
`include "arp_params.svh"

package arp_pkg;

    // Port state: idle, converting, sequencer readback
    typedef enum logic [1:0] {
        ARP_IDLE,
        ARP_CONV,
        ARP_READBACK
    } arp_state_t;

    // One conversion result with the settings it was taken with
    typedef struct packed {
        logic                  pairMode;
        logic [2:0]            chanAddr;
        logic                  bipolar;
        logic [`ARP_RES_W-1:0] code;
    } arp_word_t;

endpackage : arp_pkg

// ==== arp_stream_if.sv ====
`timescale 1ns/10ps
`default_nettype none

// Valid/ready word stream between the port and its result buffer
interface arp_stream_if #(
    parameter int W = 17
);
    logic         valid;  // Word offered
    logic         ready;  // Word accepted when both high
    logic [W-1:0] data;   // Payload

    modport source (output valid, output data, input ready);
    modport sink   (input valid, input data, output ready);
endinterface : arp_stream_if

`default_nettype wire

// ==== arp_word_fifo.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "arp_params.svh"

module arp_word_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = `ARP_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic     clk,
    input wire logic     reset_n,
    // Filling and draining sides
    arp_stream_if.sink   inQ,
    arp_stream_if.source outQ
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // Whole buffer state
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 cnt;
    } arp_fifo_st_t;

    arp_fifo_st_t q;     // Registered state
    arp_fifo_st_t d;     // Next state
    logic         push;  // Word enters
    logic         pop;   // Word leaves

    // Full and empty come straight from the count, never guessed
    assign inQ.ready  = (q.cnt != (AW+1)'(DEPTH));
    assign outQ.valid = (q.cnt != '0);
    assign outQ.data  = q.mem[q.rd];

    // Pointer and count update
    always_comb begin
        d    = q;
        push = inQ.valid && inQ.ready;
        pop  = outQ.valid && outQ.ready;
        if (push) begin
            d.mem[q.wr] = inQ.data;
            d.wr = (q.wr == AW'(DEPTH-1)) ? '0 : q.wr + 1'b1;
        end
        if (pop) begin
            d.rd = (q.rd == AW'(DEPTH-1)) ? '0 : q.rd + 1'b1;
        end
        case ({push, pop})
            2'b10:   d.cnt = q.cnt + 1'b1;
            2'b01:   d.cnt = q.cnt - 1'b1;
            default: d.cnt = q.cnt;
        endcase
    end

    // State register, synchronous reset
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // A lone push must grow the count by exactly one
    a_fifo_push_count: assert property (@(posedge clk) disable iff (!reset_n)
        (push && !pop) |=> (q.cnt == $past(q.cnt) + 1'b1))
        else $error("buffer count did not follow push");

endmodule : arp_word_fifo

`default_nettype wire

// ==== arp_core_model.sv ====
`timescale 1ns/10ps
`default_nettype none

// Converter core stand-in: answers each start after a fixed count, stretched while the port is not ready
module arp_core_model #(
    parameter int RES_W = 12,
    parameter int WAIT  = 20  // Conversion length in clocks
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // Core handshake
    input  wire logic             convStart,
    input  wire logic             convReady,
    output logic                  convDone,
    output logic [RES_W-1:0]      convCode,
    // Code to hand back, chosen by the bench
    input  wire logic [RES_W-1:0] codeIn
);
    int   cnt;     // Cycles left, 0 when idle
    logic finish;  // Last count reached while the port can take the word

    assign finish = reset_n && !convStart && (cnt == 1) && convReady;

    // Done pulse and code, each written once per edge
    always @(posedge clk) begin
        convDone <= finish;
        // Code line carries junk outside the done pulse
        convCode <= finish ? codeIn : ~codeIn;
    end

    // Count down from a start; a finish waits while the port is not ready
    always @(posedge clk) begin
        if (!reset_n) begin
            cnt <= 0;
        end else if (convStart) begin
            cnt <= WAIT;
        end else if (finish) begin
            cnt <= 0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule : arp_core_model

`default_nettype wire

// ==== arp_readback_port_bench.sv ====
`timescale 1ns/10ps
`default_nettype none

module arp_readback_port_bench;
    import arp_pkg::*;
    // Host pins, driven after each rising edge
    logic        clk = 0, resetN = 0, csN = 1, rdN = 1, launchN = 1, m0 = 1, m1 = 0;
    logic        pairSel = 0, pol = 0, gain = 0, ldValid = 0;
    logic [2:0]  chan   = 3'h0;
    logic [3:0]  ldAddr = 4'h0;
    logic [6:0]  ldData = 7'h00;
    logic [11:0] codeIn = 12'h000;
    // Design outputs
    logic        convStart, convReady, convDone, muxCom, spanBip, gainOne;
    logic        pairOut, aHi, aMid, aLo, pinsOe, busy, oeSeen;
    logic [11:0] convCode, resultPins;
    logic [2:0]  muxPos, muxNeg;
    logic [15:0] rdWord;  // Pair bit, address, result as read
    int          n_fail = 0, num_checks = 0, cycles = 0;

    always #2 clk = ~clk;

    arp_readback_port dut (.clk(clk), .reset_n(resetN), .chipSelect_n(csN),
        .readStrobe_n(rdN), .sampleLaunch_n(launchN), .modePinZero(m0), .modePinOne(m1),
        .pairInputSelect(pairSel), .channelAddrIn(chan), .polaritySpanSelect(pol),
        .gainSelect(gain), .seqLoadValid(ldValid), .seqLoadAddr(ldAddr),
        .seqLoadData(ldData), .convStart(convStart), .convReady(convReady),
        .convDone(convDone), .convCode(convCode), .muxPosSel(muxPos), .muxNegSel(muxNeg),
        .muxNegCommon(muxCom), .spanBipolar(spanBip), .gainUnity(gainOne),
        .resultPins(resultPins), .pairmodeOutBit(pairOut), .channelAddrOutHi(aHi),
        .channelAddrOutMid(aMid), .channelAddrOutLo(aLo), .pinsOe(pinsOe), .busy(busy));

    arp_core_model core (.clk(clk), .reset_n(resetN), .convStart(convStart),
        .convReady(convReady), .convDone(convDone), .convCode(convCode), .codeIn(codeIn));

    // Verdict and end of run, from the main sequence or the watchdog
    task automatic results;
        $display("checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results

    // Compare one value and count it
    task automatic chk(input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: expected %h, got %h", $time, exp, got);
        end
    endtask : chk

    // Bounded wait for busy or the pin enable to reach a level
    task automatic waitSig(input bit useOe, input logic lvl);
        for (int i = 0; i < 200; i++) begin
            @(posedge clk);
            if ((useOe ? pinsOe : busy) === lvl) begin
                return;
            end
        end
        n_fail++;
        $display("wrong value at %0t: expected %h, got %h", $time, lvl, ~lvl);
    endtask : waitSig

    // One read cycle; chip select off means no answer may come
    task automatic readWord(input logic sel);
        @(posedge clk);
        csN <= ~sel;
        rdN <= 1'b0;
        if (sel) begin
            waitSig(1'b1, 1'b1);
        end else begin
            repeat (12) @(posedge clk);
        end
        oeSeen = pinsOe;
        rdWord = {pairOut, aHi, aMid, aLo, resultPins};
        rdN <= 1'b1;
        // Select stays low through the release so the rise is seen
        if (sel) begin
            waitSig(1'b1, 1'b0);
        end
        repeat (3) @(posedge clk);
        csN <= 1'b1;
    endtask : readWord

    // Set the input pins, launch, check the mux set-up, wait for the result
    task automatic convert(input logic p, input logic [2:0] a, input logic b,
                           input logic [11:0] code);
        @(posedge clk);
        pairSel <= p;
        chan    <= a;
        pol     <= b;
        gain    <= a[0];
        codeIn  <= code;
        csN     <= 1'b0;
        repeat (6) @(posedge clk);
        launchN <= 1'b0;
        waitSig(1'b0, 1'b0);
        // Released a few clocks after the start, well inside 400 ns
        launchN <= 1'b1;
        chk({13'h0, a}, {13'h0, muxPos});
        if (p) begin
            chk({13'h0, a ^ 3'h1}, {13'h0, muxNeg});
        end
        chk({13'h0, ~p, b, a[0]}, {13'h0, muxCom, spanBip, gainOne});
        waitSig(1'b0, 1'b1);
    endtask : convert

    // Watchdog: the whole run needs a few hundred clocks
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            results();
        end
    end

    // Main sequence
    initial begin
        logic        p[4]    = '{1'b0, 1'b1, 1'b1, 1'b0};
        logic [2:0]  a[4]    = '{3'h5, 3'h2, 3'h7, 3'h0};
        logic        b[4]    = '{1'b0, 1'b1, 1'b1, 1'b1};
        logic [11:0] code[4] = '{12'h5a3, 12'h800, 12'h7ff, 12'h123};
        logic [6:0]  ent[2]  = '{7'h5b, 7'h26};
        repeat (4) @(posedge clk);
        resetN <= 1'b1;
        @(posedge clk);
        chk(16'h0002, {14'h0, busy, pinsOe});
        // Conversions over both pair modes and both spans
        for (int k = 0; k < 4; k++) begin
            convert(p[k], a[k], b[k], code[k]);
            readWord(1'b1);
            chk({p[k], a[k], b[k] ? {~code[k][11], code[k][10:0]} : code[k]}, rdWord);
        end
        readWord(1'b0);
        chk(16'h0000, {15'h0, oeSeen});
        // Two sequencer entries, then read them back in order
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            ldValid <= 1'b1;
            ldAddr  <= 4'(k);
            ldData  <= ent[k];
        end
        @(posedge clk);
        ldValid <= 1'b0;
        m1      <= 1'b1;
        @(posedge clk);
        m0 <= 1'b0;
        waitSig(1'b0, 1'b0);
        for (int k = 0; k < 2; k++) begin
            readWord(1'b1);
            chk({ent[k][6:3], ent[k][2:0], 9'h000}, rdWord);
        end
        chk(16'h0000, {15'h0, busy});
        @(posedge clk);
        m0 <= 1'b1;
        waitSig(1'b0, 1'b1);
        m1 <= 1'b0;
        results();
    end
endmodule : arp_readback_port_bench

`default_nettype wire
